/* File: core/stt_system_timer.sv */
`default_nettype none
// What this block does
// - 16-bit periodic down counter on slow clock
// - periodic zero sets flag, reloads, restarts
// - periodic mode write reloads counter immediately
// - periodic value zero means 65536 ticks
// - watchdog 16-bit counter, slow clock over 128
// - restart command reloads watchdog and divider
// - watchdog mode write only stores settings
// - watchdog value zero means 65536 times 128
// - watchdog overflow sets flag, reloads, restarts
// - pin enable drives overflow pin low 8 ticks
// - reset enable gives internal reset on overflow
// - debug mode stops the watchdog divider output
// - 20-bit seconds counter via programmable prescaler
// - prescaler resets to 0x8000
// - prescaler zero means 65536 ticks
// - prescale write reloads divider, clears seconds
// - alarm flag set when seconds match alarm
// - alarm resets to zero, the longest delay
// - increment flag set on every seconds advance
// - flags stay until status read clears them
// - enable register sets mask bits on ones
// - disable register clears mask; irq on unmasked flag
module stt_system_timer
	import stt_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_slow_clock,
	input  wire logic        i_debug_mode,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	output logic             o_overflow_out_n,
	output logic             o_wdg_reset
);
	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = v - 16'h0001;
	endfunction

	function automatic logic hit(input logic [7:0] ofs);
		hit = (i_addr == ofs);
	endfunction

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [2:0]    slow_sync_q;
	logic          tick;
	logic [15:0]   pit_reload_q;
	logic [15:0]   pit_cnt_q;
	logic          pit_event;
	stt_wdg_mode_t wdg_mode_q;
	logic [6:0]    wdg_div_q;
	logic          wdg_tick;
	logic [15:0]   wdg_cnt_q;
	logic          wdg_event;
	logic          restart;
	logic [3:0]    pin_cnt_q;
	logic [15:0]   rtt_pres_q;
	logic [15:0]   rtt_div_q;
	logic          rtt_event;
	logic [19:0]   seconds_q;
	logic [19:0]   seconds_next;
	logic [19:0]   alarm_q;
	stt_events_t   status_q;
	stt_events_t   events;
	stt_events_t   mask_q;
	logic          status_read;

	// ---------------------------------------------------------------
	// slow clock synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			slow_sync_q <= 3'b000;
		end else begin
			slow_sync_q <= {slow_sync_q[1:0], i_slow_clock};
		end
	end

	assign tick = slow_sync_q[1] & ~slow_sync_q[2];

	// ---------------------------------------------------------------
	// periodic timer
	// ---------------------------------------------------------------
	assign pit_event = tick && (dec16(pit_cnt_q) == 16'h0000);

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pit_reload_q <= STT_RST_PERIODIC;
			pit_cnt_q    <= STT_RST_PERIODIC;
		end else if (i_wr && hit(STT_OFS_PIT_MODE)) begin
			pit_reload_q <= i_wdata[15:0];
			pit_cnt_q    <= i_wdata[15:0];
		end else if (pit_event) begin
			pit_cnt_q <= pit_reload_q;
		end else if (tick) begin
			pit_cnt_q <= dec16(pit_cnt_q);
		end
	end

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	assign restart   = i_wr && hit(STT_OFS_COMMAND) && i_wdata[STT_BIT_WDG_RESTART];
	assign wdg_tick  = tick && (wdg_div_q == STT_WDG_DIV_LAST) && !i_debug_mode;
	assign wdg_event = wdg_tick && (dec16(wdg_cnt_q) == 16'h0000);

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wdg_mode_q <= '{pin_en: 1'b0, reset_en: 1'b0, reload: STT_RST_WATCHDOG};
		end else if (i_wr && hit(STT_OFS_WDG_MODE)) begin
			wdg_mode_q <= {i_wdata[STT_BIT_PIN_EN], i_wdata[STT_BIT_RESET_EN], i_wdata[15:0]};
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wdg_div_q <= 7'h00;
		end else if (restart) begin
			wdg_div_q <= 7'h00;
		end else if (tick && !(i_debug_mode && wdg_div_q == STT_WDG_DIV_LAST)) begin
			wdg_div_q <= wdg_div_q + 7'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wdg_cnt_q <= STT_RST_WATCHDOG;
		end else if (restart) begin
			wdg_cnt_q <= wdg_mode_q.reload;
		end else if (wdg_event) begin
			wdg_cnt_q <= wdg_mode_q.reload;
		end else if (wdg_tick) begin
			wdg_cnt_q <= dec16(wdg_cnt_q);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pin_cnt_q <= 4'h0;
		end else if (wdg_event && wdg_mode_q.pin_en) begin
			pin_cnt_q <= STT_PIN_PULSE_LEN;
		end else if (tick && pin_cnt_q != 4'h0) begin
			pin_cnt_q <= pin_cnt_q - 4'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_overflow_out_n <= 1'b1;
			o_wdg_reset      <= 1'b0;
		end else begin
			o_overflow_out_n <= (pin_cnt_q == 4'h0);
			o_wdg_reset      <= wdg_event && wdg_mode_q.reset_en;
		end
	end

	// ---------------------------------------------------------------
	// seconds timer
	// ---------------------------------------------------------------
	assign rtt_event    = tick && (dec16(rtt_div_q) == 16'h0000);
	assign seconds_next = seconds_q + 20'h0_0001;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rtt_pres_q <= STT_RST_PRESCALE;
			rtt_div_q  <= STT_RST_PRESCALE;
			seconds_q  <= 20'h0_0000;
		end else if (i_wr && hit(STT_OFS_RTT_MODE)) begin
			rtt_pres_q <= i_wdata[15:0];
			rtt_div_q  <= i_wdata[15:0];
			seconds_q  <= 20'h0_0000;
		end else if (rtt_event) begin
			rtt_div_q <= rtt_pres_q;
			seconds_q <= seconds_next;
		end else if (tick) begin
			rtt_div_q <= dec16(rtt_div_q);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			alarm_q <= STT_RST_ALARM;
		end else if (i_wr && hit(STT_OFS_ALARM)) begin
			alarm_q <= i_wdata[19:0];
		end
	end

	// ---------------------------------------------------------------
	// status and mask
	// ---------------------------------------------------------------
	assign status_read = i_rd && hit(STT_OFS_STATUS);

	always_comb begin
		events.periodic  = pit_event;
		events.overflow  = wdg_event;
		events.increment = rtt_event;
		events.alarm     = rtt_event && (seconds_next == alarm_q);
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			status_q <= '0;
		end else if (status_read) begin
			status_q <= events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			mask_q <= '0;
		end else if (i_wr && hit(STT_OFS_IRQ_SET)) begin
			mask_q <= mask_q | i_wdata[3:0];
		end else if (i_wr && hit(STT_OFS_IRQ_CLEAR)) begin
			mask_q <= mask_q & ~i_wdata[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_q & mask_q);
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				STT_OFS_PIT_MODE:  o_rdata <= {16'h0000, pit_reload_q};
				STT_OFS_WDG_MODE:  o_rdata <= {14'h0000, wdg_mode_q};
				STT_OFS_RTT_MODE:  o_rdata <= {16'h0000, rtt_pres_q};
				STT_OFS_STATUS:    o_rdata <= {28'h000_0000, status_q};
				STT_OFS_IRQ_MASK:  o_rdata <= {28'h000_0000, mask_q};
				STT_OFS_ALARM:     o_rdata <= {12'h000, alarm_q};
				STT_OFS_SECONDS:   o_rdata <= {12'h000, seconds_q};
				default:           o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* File: core/stt_pkg.sv */
`default_nettype none
package stt_pkg;
	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] STT_OFS_COMMAND    = 8'h00;
	localparam logic [7:0] STT_OFS_PIT_MODE   = 8'h04;
	localparam logic [7:0] STT_OFS_WDG_MODE   = 8'h08;
	localparam logic [7:0] STT_OFS_RTT_MODE   = 8'h0C;
	localparam logic [7:0] STT_OFS_STATUS     = 8'h10;
	localparam logic [7:0] STT_OFS_IRQ_SET    = 8'h14;
	localparam logic [7:0] STT_OFS_IRQ_CLEAR  = 8'h18;
	localparam logic [7:0] STT_OFS_IRQ_MASK   = 8'h1C;
	localparam logic [7:0] STT_OFS_ALARM      = 8'h20;
	localparam logic [7:0] STT_OFS_SECONDS    = 8'h24;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int STT_BIT_WDG_RESTART = 0;
	localparam int STT_BIT_RESET_EN    = 16;
	localparam int STT_BIT_PIN_EN      = 17;
	localparam int STT_BIT_PERIODIC    = 0;
	localparam int STT_BIT_OVERFLOW    = 1;
	localparam int STT_BIT_INCREMENT   = 2;
	localparam int STT_BIT_ALARM       = 3;

	// ---------------------------------------------------------------
	// reset values and counts
	// ---------------------------------------------------------------
	localparam logic [15:0] STT_RST_PERIODIC  = 16'h0000;
	localparam logic [15:0] STT_RST_WATCHDOG  = 16'h0000;
	localparam logic [15:0] STT_RST_PRESCALE  = 16'h8000;
	localparam logic [19:0] STT_RST_ALARM     = 20'h0_0000;
	localparam logic [6:0]  STT_WDG_DIV_LAST  = 7'h7F;
	localparam logic [3:0]  STT_PIN_PULSE_LEN = 4'h8;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        pin_en;
		logic        reset_en;
		logic [15:0] reload;
	} stt_wdg_mode_t;

	typedef struct packed {
		logic alarm;
		logic increment;
		logic overflow;
		logic periodic;
	} stt_events_t;
endpackage
`default_nettype wire

/* File: tb/stt_system_timer_assertions.sv */
`default_nettype none
module stt_system_timer_chk
	import stt_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic        i_slow_clock,
	input wire logic        i_debug_mode,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        o_irq,
	input wire logic        o_overflow_out_n,
	input wire logic        o_wdg_reset
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	logic       rst_en_q, pin_en_q, slow_q;
	logic [3:0] ticks_q;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rst_en_q <= 1'b0;
			pin_en_q <= 1'b0;
		end else if (i_wr && i_addr == STT_OFS_WDG_MODE) begin
			rst_en_q <= i_wdata[STT_BIT_RESET_EN];
			pin_en_q <= i_wdata[STT_BIT_PIN_EN];
		end
	end
	always_ff @(posedge i_clk) begin
		slow_q <= i_slow_clock;
		if (o_overflow_out_n)
			ticks_q <= 4'h0;
		else if (i_slow_clock && !slow_q && ticks_q != 4'hF)
			ticks_q <= ticks_q + 4'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_alarm_wr_rd;
		i_wr && i_addr == STT_OFS_ALARM ##2 i_rd && i_addr == STT_OFS_ALARM;
	endsequence
	sequence s_rtt_wr_rd;
		i_wr && i_addr == STT_OFS_RTT_MODE ##2 i_rd && i_addr == STT_OFS_SECONDS;
	endsequence
	chk_alarm_readback: assert property (s_alarm_wr_rd |=> o_rdata == {12'h0, $past(i_wdata[19:0], 3)})
		else $error("alarm readback wrong");
	chk_seconds_clear: assert property (s_rtt_wr_rd |=> o_rdata == 32'h0)
		else $error("seconds not cleared");
	chk_irq_off: assert property (i_wr && i_addr == STT_OFS_IRQ_CLEAR && i_wdata[3:0] == 4'hF |-> ##2 !o_irq)
		else $error("irq while masked");
	chk_reset_pulse: assert property (o_wdg_reset |=> !o_wdg_reset)
		else $error("reset pulse too long");
	chk_reset_gate: assert property (o_wdg_reset |-> rst_en_q)
		else $error("reset while disabled");
	chk_pin_gate: assert property ($fell(o_overflow_out_n) |-> pin_en_q)
		else $error("pin while disabled");
	chk_pin_length: assert property ($rose(o_overflow_out_n) |-> ticks_q inside {[7:9]})
		else $error("pin pulse length");
	chk_debug_quiet: assert property (i_debug_mode [*8] |-> !o_wdg_reset)
		else $error("reset in debug");
endmodule
bind stt_system_timer stt_system_timer_chk u_stt_system_timer_chk (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow_clock(i_slow_clock), .i_debug_mode(i_debug_mode),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_overflow_out_n(o_overflow_out_n), .o_wdg_reset(o_wdg_reset)
);
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top
	import stt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// stimulus and checks
	// ---------------------------------------------------------------
	logic        i_clk = 1'b0;
	logic        i_slow_clock = 1'b0;
	logic        i_reset_n, i_debug_mode, i_wr, i_rd;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	logic        o_irq, o_overflow_out_n, o_wdg_reset, rst_seen, pin_seen;
	logic [2:0]  sdiv = 3'h0;
	logic [3:0]  m;
	int          errors, cmp_count, cyc, c, n;
	always #2.5 i_clk = ~i_clk;
	stt_system_timer u_stt_system_timer (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow_clock(i_slow_clock), .i_debug_mode(i_debug_mode),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
		.o_overflow_out_n(o_overflow_out_n), .o_wdg_reset(o_wdg_reset)
	);
	always @(posedge i_clk) begin
		sdiv <= sdiv + 3'h1;
		i_slow_clock <= sdiv[2];
		cyc++;
		if (o_wdg_reset === 1'b1) rst_seen = 1'b1;
		if (o_overflow_out_n === 1'b0) pin_seen = 1'b1;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end
	function automatic bit in_win(int cnt, int ticks, int per);
		return cnt >= (ticks - 1) * per && cnt <= ticks * per + 12;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask
	task automatic wait_irq();
		c = 0;
		#1;
		while (o_irq !== 1'b1 && c < 3000) begin
			@(posedge i_clk);
			#1 c++;
		end
	endtask
	task test_done();
		if (errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		i_reset_n = 1'b0;
		i_debug_mode = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		m = 4'h0;
		c = $urandom(49882);
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		rd(STT_OFS_RTT_MODE);
		`CHK(d, 32'h0000_8000)
		rd(STT_OFS_ALARM);
		`CHK(d, 32'h0)
		rd(8'h30);
		`CHK(d, 32'h0)
		wr(STT_OFS_PIT_MODE, 32'h2);
		repeat (40) @(posedge i_clk);
		wr(STT_OFS_PIT_MODE, 32'h0);
		rd(STT_OFS_STATUS);
		`CHK(d[0], 1'b1)
		rd(STT_OFS_STATUS);
		`CHK(d, 32'h0)
		`CHK(o_irq, 1'b0)
		repeat (8) begin
			n = $urandom;
			wr(n[4] ? STT_OFS_IRQ_SET : STT_OFS_IRQ_CLEAR, {28'h0, n[3:0]});
			m = n[4] ? m | n[3:0] : m & ~n[3:0];
			rd(STT_OFS_IRQ_MASK);
			`CHK(d, {28'h0, m})
		end
		wr(STT_OFS_IRQ_CLEAR, 32'hF);
		wr(STT_OFS_IRQ_SET, 32'h1);
		repeat (3) begin
			n = 2 + $urandom % 4;
			wr(STT_OFS_PIT_MODE, 32'h0);
			rd(STT_OFS_STATUS);
			wr(STT_OFS_PIT_MODE, 32'(n));
			wait_irq();
			`CHK(in_win(c, n, 8), 1'b1)
		end
		wr(STT_OFS_IRQ_CLEAR, 32'h1);
		wr(STT_OFS_IRQ_SET, 32'h8);
		wr(STT_OFS_ALARM, 32'h3);
		rd(STT_OFS_ALARM);
		`CHK(d, 32'h3)
		wr(STT_OFS_RTT_MODE, 32'h2);
		rd(STT_OFS_SECONDS);
		`CHK(d, 32'h0)
		wait_irq();
		`CHK(in_win(c, 6, 8), 1'b1)
		rd(STT_OFS_STATUS);
		`CHK(d[3:2], 2'b11)
		rd(STT_OFS_SECONDS);
		do begin
			n = d;
			rd(STT_OFS_SECONDS);
		end while (d !== n);
		`CHK(d[19:0] >= 20'h0_0003, 1'b1)
		wr(STT_OFS_PIT_MODE, 32'h0);
		wr(STT_OFS_RTT_MODE, 32'h0);
		wr(STT_OFS_IRQ_CLEAR, 32'h8);
		wr(STT_OFS_IRQ_SET, 32'h2);
		for (n = 0; n < 3; n++) begin
			wr(STT_OFS_WDG_MODE, n == 2 ? 32'h1 : 32'h0003_0001);
			i_debug_mode <= (n == 1);
			wr(STT_OFS_COMMAND, 32'h1);
			rd(STT_OFS_STATUS);
			rst_seen = 1'b0;
			pin_seen = 1'b0;
			wait_irq();
			`CHK(in_win(c, 128, 8), n != 1)
			repeat (80) @(posedge i_clk);
			`CHK(rst_seen, n == 0)
			`CHK(pin_seen, n == 0)
		end
		test_done();
	end
endmodule
`default_nettype wire
